// file: rtl/phm_regs.sv
// phm_regs: protected high-memory region register file and decoder.
// assumes a classic wishbone master; single clock, async active-low reset.
// Contract
// - when high region unsupported, base and limit are read-only and ignore writes.
// - low reserved bits of base decode as zeros, giving base alignment.
// - low reserved bits of limit decode as ones, covering a whole block.
// - unimplemented low bits read zero; software finds alignment from read-back.
// - equal base and limit upper bits protect two to the N plus one bytes.
// - limit below base disables the region entirely.
// - bits at and above host address width are unimplemented and ignored.
// - region may sit anywhere implemented, above or below 4 gigabytes.
// - decoded limit is the last protected address, range inclusive.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module phm_regs #(
    parameter int HOST_ADDRESS_WIDTH = phm_pkg::HAW_DEFAULT,
    parameter int RSVD = phm_pkg::RSVD_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // capability strap
    input wire logic high_region_supported,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [phm_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // dma check
    input wire logic dma_valid,
    input wire logic [63:0] dma_addr,
    output logic dma_block_q,
    output logic dma_done_q,
    // status
    output logic protection_active_status
);
    // implemented bits: RSVD+1 .. HOST_ADDRESS_WIDTH-1
    localparam logic [63:0] IMPL_MASK =
        ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~((64'h1 << (RSVD + 1)) - 64'h1);
    localparam logic [63:0] LOW_ONES = (64'h1 << (RSVD + 1)) - 64'h1;

    logic [63:0] high_region_base_q;
    logic [63:0] high_region_limit_q;
    logic enable_q;
    logic hit_seen_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdata_q;
    logic req;
    logic wr_go;
    logic known;
    logic [31:0] bmask;
    logic [63:0] base_dec;
    logic [63:0] limit_dec;
    logic rgn_valid;

    phm_region_if #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) rgn ();

    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign wr_go = req && wb_we_i && known;
    assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        known = 1'b1;
        if (wb_adr_i == phm_pkg::BASE_LO_OFF) begin
            known = 1'b1;
        end else if (wb_adr_i == phm_pkg::BASE_HI_OFF) begin
            known = 1'b1;
        end else if (wb_adr_i == phm_pkg::LIMIT_LO_OFF) begin
            known = 1'b1;
        end else if (wb_adr_i == phm_pkg::LIMIT_HI_OFF) begin
            known = 1'b1;
        end else if (wb_adr_i == phm_pkg::CTRL_OFF) begin
            known = 1'b1;
        end else if (wb_adr_i == phm_pkg::STAT_OFF) begin
            known = 1'b1;
        end else begin
            known = 1'b0;
        end
    end

    // base and limit writes; unimplemented bits never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_region_base_q <= phm_pkg::REG_RESET;
            high_region_limit_q <= phm_pkg::REG_RESET;
        end else if (wr_go && high_region_supported) begin
            // writes while active are not blocked: software keeps them out
            if (wb_adr_i == phm_pkg::BASE_LO_OFF) begin
                high_region_base_q[31:0] <= ((high_region_base_q[31:0] & ~bmask)
                    | (wb_dat_i & bmask)) & IMPL_MASK[31:0];
            end else if (wb_adr_i == phm_pkg::BASE_HI_OFF) begin
                high_region_base_q[63:32] <= ((high_region_base_q[63:32] & ~bmask)
                    | (wb_dat_i & bmask)) & IMPL_MASK[63:32];
            end else if (wb_adr_i == phm_pkg::LIMIT_LO_OFF) begin
                high_region_limit_q[31:0] <= ((high_region_limit_q[31:0] & ~bmask)
                    | (wb_dat_i & bmask)) & IMPL_MASK[31:0];
            end else if (wb_adr_i == phm_pkg::LIMIT_HI_OFF) begin
                high_region_limit_q[63:32] <= ((high_region_limit_q[63:32] & ~bmask)
                    | (wb_dat_i & bmask)) & IMPL_MASK[63:32];
            end
        end
    end

    // protection enable, a stand-in for the wider enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
        end else if (wr_go && wb_adr_i == phm_pkg::CTRL_OFF && wb_sel_i[0]) begin
            enable_q <= wb_dat_i[phm_pkg::CTRL_ENABLE_BIT];
        end
    end

    // sticky record of any blocked access, cleared by writing one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_seen_q <= 1'b0;
        end else if (dma_done_q && dma_block_q) begin
            hit_seen_q <= 1'b1;
        end else if (wr_go && wb_adr_i == phm_pkg::STAT_OFF && wb_sel_i[0]
                && wb_dat_i[phm_pkg::STAT_HIT_BIT]) begin
            hit_seen_q <= 1'b0;
        end
    end

    // decoded bounds: base low bits zero, limit low bits one
    assign base_dec = high_region_base_q & IMPL_MASK;
    assign limit_dec = (high_region_limit_q & IMPL_MASK) | LOW_ONES;
    // full-width compare works above and below 4 GB alike
    assign rgn_valid = limit_dec >= (base_dec | LOW_ONES) || limit_dec >= base_dec
        ? (high_region_limit_q & IMPL_MASK) >= base_dec : 1'b0;

    assign rgn.base_dec = base_dec[HOST_ADDRESS_WIDTH-1:0];
    assign rgn.limit_dec = limit_dec[HOST_ADDRESS_WIDTH-1:0];
    assign rgn.valid = rgn_valid;
    assign rgn.enable = enable_q;
    assign protection_active_status = enable_q;

    // one-cycle answer; unmapped addresses get err
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req && known;
            err_q <= req && !known;
            if (req && !wb_we_i) begin
                if (wb_adr_i == phm_pkg::BASE_LO_OFF) begin
                    rdata_q <= high_region_base_q[31:0];
                end else if (wb_adr_i == phm_pkg::BASE_HI_OFF) begin
                    rdata_q <= high_region_base_q[63:32];
                end else if (wb_adr_i == phm_pkg::LIMIT_LO_OFF) begin
                    rdata_q <= high_region_limit_q[31:0];
                end else if (wb_adr_i == phm_pkg::LIMIT_HI_OFF) begin
                    rdata_q <= high_region_limit_q[63:32];
                end else if (wb_adr_i == phm_pkg::CTRL_OFF) begin
                    rdata_q <= {31'h0, enable_q};
                end else if (wb_adr_i == phm_pkg::STAT_OFF) begin
                    rdata_q <= {28'h0, hit_seen_q, rgn_valid, high_region_supported, enable_q};
                end else begin
                    rdata_q <= 32'h0;
                end
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;

    phm_range_check #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) u_check (
        .clk(clk),
        .rst_n(rst_n),
        .rgn(rgn.check),
        .dma_valid(dma_valid),
        .dma_addr(dma_addr),
        .dma_block_q(dma_block_q),
        .dma_done_q(dma_done_q)
    );

    ro_unsupported_a: assert property (@(posedge clk) disable iff (!rst_n)
        !high_region_supported |=> $stable(high_region_base_q)
        && $stable(high_region_limit_q))
        else $error("base or limit changed while unsupported");
    low_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (high_region_base_q & ~IMPL_MASK) == 64'h0
        && (high_region_limit_q & ~IMPL_MASK) == 64'h0)
        else $error("unimplemented bits stored");
    limit_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
        (limit_dec & LOW_ONES) == LOW_ONES)
        else $error("limit low bits not decoded as ones");
    below_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (high_region_limit_q & IMPL_MASK) < base_dec |-> !rgn_valid)
        else $error("region valid with limit below base");
    equal_size_a: assert property (@(posedge clk) disable iff (!rst_n)
        (high_region_limit_q & IMPL_MASK) == base_dec
        |-> rgn_valid && (limit_dec - base_dec) == LOW_ONES)
        else $error("equal bounds do not give one aligned block");
    read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        req && !wb_we_i && wb_adr_i == phm_pkg::BASE_HI_OFF
        |=> wb_ack_o && wb_dat_o == $past(high_region_base_q[63:32]))
        else $error("base upper read-back wrong");

    // bus handshake: one answer per request, never both kinds at once
    ack_one_shot_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_err_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err raised together");
    mapped_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        req && known |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        req && !known |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");

    // a full-word write lands with only implemented bits kept
    base_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && high_region_supported && wb_sel_i == 4'hf
        && wb_adr_i == phm_pkg::BASE_LO_OFF
        |=> high_region_base_q[31:0] == ($past(wb_dat_i) & IMPL_MASK[31:0]))
        else $error("base low word not stored as written");
    limit_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && high_region_supported && wb_sel_i == 4'hf
        && wb_adr_i == phm_pkg::LIMIT_HI_OFF
        |=> high_region_limit_q[63:32] == ($past(wb_dat_i) & IMPL_MASK[63:32]))
        else $error("limit high word not stored as written");
    base_zeros_a: assert property (@(posedge clk) disable iff (!rst_n)
        (base_dec & LOW_ONES) == 64'h0)
        else $error("base low bits not decoded as zeros");
    valid_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        rgn_valid |-> limit_dec >= base_dec)
        else $error("valid region ends before it starts");

    // enable and sticky hit follow their writers; a new hit beats a clear
    enable_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && wb_adr_i == phm_pkg::CTRL_OFF && wb_sel_i[0]
        |=> enable_q == $past(wb_dat_i[phm_pkg::CTRL_ENABLE_BIT]))
        else $error("enable bit not updated by write");
    hit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        dma_done_q && dma_block_q |=> hit_seen_q)
        else $error("blocked access not recorded");
    dma_verdict_a: assert property (@(posedge clk) disable iff (!rst_n)
        dma_valid |=> dma_done_q)
        else $error("dma check gave no verdict");
endmodule
`default_nettype wire

// file: rtl/phm_pkg.sv
// phm_pkg: offsets, field layout, reset values and widths for the
// protected high-memory region block.
// assumes a 32-bit classic wishbone register bus with byte addresses.
package phm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] BASE_LO_OFF = 8'h70;
    localparam logic [7:0] BASE_HI_OFF = 8'h74;
    localparam logic [7:0] LIMIT_LO_OFF = 8'h78;
    localparam logic [7:0] LIMIT_HI_OFF = 8'h7c;
    localparam logic [7:0] CTRL_OFF = 8'h60;
    localparam logic [7:0] STAT_OFF = 8'h64;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_SUPPORTED_BIT = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_HIT_BIT = 3;
    localparam logic [63:0] REG_RESET = 64'h0;
    localparam int HAW_DEFAULT = 48;
    localparam int RSVD_DEFAULT = 11;
endpackage

// file: rtl/phm_region_if.sv
// phm_region_if: decoded region bounds passed from the register file
// to the range checker.
// assumes one clock domain; all signals are levels.
`timescale 1ns/1ns
`default_nettype none
interface phm_region_if #(parameter int HOST_ADDRESS_WIDTH = 48);
    logic [HOST_ADDRESS_WIDTH-1:0] base_dec;
    logic [HOST_ADDRESS_WIDTH-1:0] limit_dec;
    logic valid;
    logic enable;
    modport regs (output base_dec, output limit_dec, output valid, output enable);
    modport check (input base_dec, input limit_dec, input valid, input enable);
endinterface
`default_nettype wire

// file: rtl/phm_range_check.sv
// phm_range_check: compares a dma address against the decoded region.
// assumes bounds come from phm_regs on the same clock.
`timescale 1ns/1ns
`default_nettype none
module phm_range_check #(
    parameter int HOST_ADDRESS_WIDTH = 48
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // region bounds
    phm_region_if.check rgn,
    // dma request
    input wire logic dma_valid,
    input wire logic [63:0] dma_addr,
    // verdict
    output logic dma_block_q,
    output logic dma_done_q
);
    logic hit;
    // upper address bits are not decoded limit inclusive
    assign hit = rgn.enable && rgn.valid
        && (dma_addr[HOST_ADDRESS_WIDTH-1:0] >= rgn.base_dec)
        && (dma_addr[HOST_ADDRESS_WIDTH-1:0] <= rgn.limit_dec);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_block_q <= 1'b0;
            dma_done_q <= 1'b0;
        end else begin
            dma_block_q <= dma_valid && hit;
            dma_done_q <= dma_valid;
        end
    end

    block_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        dma_done_q && dma_block_q |-> $past(rgn.enable) && $past(rgn.valid))
        else $error("block raised without an enabled valid region");
    limit_incl_a: assert property (@(posedge clk) disable iff (!rst_n)
        dma_valid && rgn.enable && rgn.valid && dma_addr[HOST_ADDRESS_WIDTH-1:0] == rgn.limit_dec
        |=> dma_block_q)
        else $error("limit address itself not blocked");
    base_incl_a: assert property (@(posedge clk) disable iff (!rst_n)
        dma_valid && rgn.enable && rgn.valid && dma_addr[HOST_ADDRESS_WIDTH-1:0] == rgn.base_dec
        |=> dma_block_q)
        else $error("base address itself not blocked");
endmodule
`default_nettype wire

// file: verif/tb.sv
// tb: self-checking bench for the protected high-memory region registers.
// assumes phm_regs is the top block, driven over classic wishbone.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int HOST_ADDRESS_WIDTH = 48;
    localparam int RSVD = 11;
    localparam logic [63:0] IMPL = ((64'h1 << HOST_ADDRESS_WIDTH) - 1) & ~((64'h1 << (RSVD + 1)) - 1);
    logic clk, rst_n, sup, cyc, stb, we, dv, ack, err, blk, done, act;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, rd;
    logic [63:0] daddr;
    logic er;
    int n_errors = 0;
    int compares = 0;

    phm_regs #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH), .RSVD(RSVD)) dut (
        .clk(clk), .rst_n(rst_n), .high_region_supported(sup),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .dma_valid(dv), .dma_addr(daddr), .dma_block_q(blk),
        .dma_done_q(done), .protection_active_status(act)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; the request stands until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
        rd = rdat;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr64(input logic [7:0] a, input logic [63:0] v);
        wb(1'b1, a, v[31:0]);
        wb(1'b1, a + 8'h4, v[63:32]);
    endtask

    task automatic rd64(input logic [7:0] a, input logic [63:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp[31:0]);
        wb(1'b0, a + 8'h4, 32'h0);
        chk(rd, exp[63:32]);
    endtask

    // verdict appears one cycle after the address is taken
    task automatic dma(input logic [63:0] a, input logic exp);
        dv <= 1'b1;
        daddr <= a;
        @(posedge clk);
        dv <= 1'b0;
        @(posedge clk);
        chk({30'h0, done, blk}, {30'h0, 1'b1, exp});
    endtask

    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        wb(1'b0, phm_pkg::STAT_OFF, 32'h0);
        chk(rd & mask, exp);
    endtask

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        stop_test;
    end

    initial begin
        rst_n = 1'b0;
        sup = 1'b1;
        {cyc, stb, we, dv} = 4'h0;
        adr = 8'h0;
        wdat = 32'h0;
        daddr = 64'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd64(phm_pkg::BASE_LO_OFF, phm_pkg::REG_RESET);
        rd64(phm_pkg::LIMIT_LO_OFF, phm_pkg::REG_RESET);
        wr64(phm_pkg::BASE_LO_OFF, '1);
        rd64(phm_pkg::BASE_LO_OFF, IMPL);
        wr64(phm_pkg::LIMIT_LO_OFF, '1);
        rd64(phm_pkg::LIMIT_LO_OFF, IMPL);
        wb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        // one aligned block above 4 gigabytes, low base bits written as ones
        wr64(phm_pkg::BASE_LO_OFF, 64'h1_0000_0fff);
        wr64(phm_pkg::LIMIT_LO_OFF, 64'h1_0000_0000);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h1);
        stat(32'h7, 32'h7);
        chk({31'h0, act}, 32'h1);
        dma(64'h1_0000_0000, 1'b1);
        dma(64'h1_0000_0fff, 1'b1);
        dma(64'h1_0000_1000, 1'b0);
        dma(64'h0_ffff_ffff, 1'b0);
        stat(32'h8, 32'h8);
        wb(1'b1, phm_pkg::STAT_OFF, 32'h8);
        stat(32'h8, 32'h0);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h0);
        dma(64'h1_0000_0000, 1'b0);
        // bounds are only rewritten while protection is off
        // limit below base switches the region off
        wr64(phm_pkg::LIMIT_LO_OFF, 64'h0_ffff_f000);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h1);
        stat(32'h7, 32'h3);
        dma(64'h1_0000_0000, 1'b0);
        dma(64'h0_ffff_f000, 1'b0);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h0);
        // two blocks below 4 gigabytes
        wr64(phm_pkg::BASE_LO_OFF, 64'h8_0000);
        wr64(phm_pkg::LIMIT_LO_OFF, 64'h8_1000);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h1);
        dma(64'h8_1fff, 1'b1);
        dma(64'h8_2000, 1'b0);
        dma(64'h7_ffff, 1'b0);
        wb(1'b1, phm_pkg::CTRL_OFF, 32'h0);
        // without the capability the bounds ignore writes
        sup <= 1'b0;
        wr64(phm_pkg::BASE_LO_OFF, 64'h5555_5555_5555_5555);
        rd64(phm_pkg::BASE_LO_OFF, 64'h8_0000);
        wr64(phm_pkg::LIMIT_LO_OFF, 64'h0);
        rd64(phm_pkg::LIMIT_LO_OFF, 64'h8_1000);
        stat(32'h2, 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire
